// file: design/pcc_pkg.sv
package pcc_pkg;
	// clock rate and the microsecond tick derived from it
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 1;
	localparam int CYC_PER_US = CLK_MHZ * TICK_US;
	// register offsets: writable settings
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RBAR_CFG = 8'h04;
	localparam logic [7:0] OFF_RBAR_SIZE0 = 8'h08;
	localparam logic [7:0] OFF_LTR_LAT = 8'h14;
	localparam logic [7:0] OFF_LTR_GAP = 8'h18;
	localparam logic [7:0] OFF_LINK_CFG = 8'h1c;
	localparam logic [7:0] OFF_EXT_CFG = 8'h20;
	// register offsets: read-only capability images and status
	localparam logic [7:0] OFF_PMC = 8'h40;
	localparam logic [7:0] OFF_PMCSR = 8'h44;
	localparam logic [7:0] OFF_RBAR_IMG0 = 8'h48;
	localparam logic [7:0] OFF_AER = 8'h60;
	localparam logic [7:0] OFF_ARI = 8'h64;
	localparam logic [7:0] OFF_PB = 8'h68;
	localparam logic [7:0] OFF_LTR_IMG = 8'h6c;
	localparam logic [7:0] OFF_EXT_HDR = 8'h70;
	localparam logic [7:0] OFF_LTR_STAT = 8'h74;
	// control register bit positions
	localparam int CB_PME_D3HOT = 0;
	localparam int CB_PME_D1 = 1;
	localparam int CB_PME_D0 = 2;
	localparam int CB_D1_SUP = 3;
	localparam int CB_NO_SOFT_RST = 4;
	localparam int CB_RBAR_EN = 5;
	localparam int CB_ECRC_CHK = 6;
	localparam int CB_ECRC_GEN = 7;
	localparam int CB_ALT_RID = 8;
	localparam int CB_PB_SYS = 9;
	localparam int CB_LTR_ON_EN = 10;
	localparam int CB_LTR_ON_PWR = 11;
	localparam int CB_DOWNSTREAM = 12;
	// capability field positions
	localparam int PMC_D3HOT_BIT = 14;
	localparam int PMC_D1_BIT = 12;
	localparam int PMC_D0_BIT = 11;
	localparam int PMC_D1SUP_BIT = 9;
	localparam int PMCSR_NSR_BIT = 3;
	localparam int RBAR_CNT_LSB = 5;
	localparam int RBAR_SIZE_LSB = 4;
	localparam int AER_CHK_BIT = 7;
	localparam int AER_GEN_BIT = 5;
	localparam int ARI_NF_LSB = 8;
	localparam int PB_SYS_BIT = 0;
	localparam int LTR_NS_LSB = 16;
	localparam int EXT_NEXT_LSB = 20;
	localparam int EXT_VER_LSB = 16;
	// reset values, the D0 power state and the bus response codes
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [9:0] RST_LTR_GAP = 10'h000;
	localparam logic [1:0] PWR_D0 = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// latency message carried to the transmit stream
	typedef struct packed {
		logic snoop_req;
		logic [9:0] snoop_lat;
		logic nosnoop_req;
		logic [9:0] nosnoop_lat;
	} pcc_ltr_msg_s;
	// decoded requester ID; dev is zero when ARI is on
	typedef struct packed {
		logic [7:0] bus;
		logic [4:0] dev;
		logic [7:0] func;
	} pcc_rid_s;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_GAP = 2'b10
	} pcc_ltr_st_e;
endpackage

// file: design/pcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_top #(
	parameter int NUM_FUNC = 2,
	parameter int NUM_RBAR = 3
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic ltr_enable_i,
	input wire logic dl_up_i,
	input wire logic [2*NUM_FUNC-1:0] func_power_state_i,
	input wire logic [15:0] rid_i,
	output pcc_pkg::pcc_rid_s rid_o,
	output logic [7:0] ts_link_number_o,
	output logic ts_link_valid_o,
	output logic ltr_enable_o,
	output logic [2*NUM_FUNC-1:0] func_power_state_o,
	output logic ltr_valid_o,
	input wire logic ltr_ready_i,
	output pcc_pkg::pcc_ltr_msg_s ltr_msg_o
);
	import pcc_pkg::*;

	// only three resizable BAR slots exist in the map
	if (NUM_FUNC < 1 || NUM_RBAR < 1 || NUM_RBAR > 3) begin : g_chk
		$error("pcc_top: unsupported NUM_FUNC or NUM_RBAR");
	end

	logic [31:0] ctrl;
	logic [11:0] rbar_cfg;
	logic [19:0] rbar_size [3];
	logic [9:0] snoop_lat, nosnoop_lat, gap_us_cfg;
	logic [15:0] link_cfg;
	logic [15:0] ext_cfg;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// byte-lane merge for a 32-bit word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// write channel: address and data taken in either order
	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_held && !s_axi_bvalid_o;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (aw_held && w_held) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
		end
	end

	wire wr_go = aw_held && w_held;
	wire [7:0] wa = {aw_addr[7:2], 2'b00};
	wire wr_hit = wa <= OFF_EXT_CFG;

	// addressed settings word before the write, merged with the enabled byte lanes
	logic [31:0] wr_old, wr_new;
	always_comb begin
		wr_old = 32'h0;
		case (wa)
			OFF_CTRL: wr_old = ctrl;
			OFF_RBAR_CFG: wr_old = {20'h0, rbar_cfg};
			OFF_LTR_LAT: wr_old = {6'h0, nosnoop_lat, 6'h0, snoop_lat};
			OFF_LTR_GAP: wr_old = {22'h0, gap_us_cfg};
			OFF_LINK_CFG: wr_old = {16'h0, link_cfg};
			OFF_EXT_CFG: wr_old = {16'h0, ext_cfg};
			default: begin
				for (int i = 0; i < 3; i++) begin
					if (wa == OFF_RBAR_SIZE0 + 8'(4 * i)) begin
						wr_old = {12'h0, rbar_size[i]};
					end
				end
			end
		endcase
		wr_new = merge(wr_old, w_data, w_strb);
	end

	// settings registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= RST_CTRL;
			rbar_cfg <= 12'h000;
			rbar_size <= '{default: 20'h00000};
			snoop_lat <= 10'h000;
			nosnoop_lat <= 10'h000;
			gap_us_cfg <= RST_LTR_GAP;
			link_cfg <= 16'h0000;
			ext_cfg <= 16'h0000;
		end else if (wr_go) begin
			case (wa)
				OFF_CTRL: ctrl <= wr_new & 32'h0000_1fff;
				OFF_RBAR_CFG: rbar_cfg <= wr_new[11:0];
				OFF_LTR_LAT: begin
					snoop_lat <= wr_new[9:0];
					nosnoop_lat <= wr_new[25:16];
				end
				OFF_LTR_GAP: gap_us_cfg <= wr_new[9:0];
				OFF_LINK_CFG: link_cfg <= wr_new[15:0];
				OFF_EXT_CFG: ext_cfg <= wr_new[15:0];
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (wa == OFF_RBAR_SIZE0 + 8'(4 * i)) begin
							rbar_size[i] <= wr_new[19:0];
						end
					end
				end
			endcase
		end
	end

	// write response follows both halves
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// capability images built from the settings
	logic [31:0] pmc_img, pmcsr_img, aer_img, ari_img, pb_img, ltr_img, ext_img;
	logic [31:0] rbar_cap_img [3];
	logic [31:0] rbar_ctl_img [3];
	logic [2:0] rbar_idx [3];
	wire [2:0] rbar_cnt = rbar_cfg[2:0];
	wire rbar_en = ctrl[CB_RBAR_EN];
	always_comb begin
		pmc_img = 32'h0;
		pmc_img[PMC_D3HOT_BIT] = ctrl[CB_PME_D3HOT];
		pmc_img[PMC_D1_BIT] = ctrl[CB_PME_D1];
		pmc_img[PMC_D0_BIT] = ctrl[CB_PME_D0];
		pmc_img[PMC_D1SUP_BIT] = ctrl[CB_D1_SUP];
		pmcsr_img = 32'h0;
		pmcsr_img[PMCSR_NSR_BIT] = ctrl[CB_NO_SOFT_RST];
		aer_img = 32'h0;
		aer_img[AER_CHK_BIT] = ctrl[CB_ECRC_CHK];
		aer_img[AER_GEN_BIT] = ctrl[CB_ECRC_GEN];
		ari_img = {16'h0, link_cfg[15:8], 8'h00};
		pb_img = 32'h0;
		pb_img[PB_SYS_BIT] = ctrl[CB_PB_SYS];
		ltr_img = {6'h0, nosnoop_lat, 6'h0, snoop_lat};
		ext_img = {ext_cfg[11:0], ext_cfg[15:12], 16'h0000};
	end

	// index entries clamped upward and blanked past the count
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			rbar_idx[i] = rbar_cfg[3 + 3*i +: 3];
			if (i > 0 && rbar_idx[i] < rbar_idx[i-1]) begin
				rbar_idx[i] = rbar_idx[i-1];
			end
		end
		for (int i = 0; i < 3; i++) begin
			rbar_cap_img[i] = 32'h0;
			rbar_ctl_img[i] = 32'h0;
			if (rbar_en && 3'(i) < rbar_cnt && i < NUM_RBAR) begin
				rbar_cap_img[i][RBAR_SIZE_LSB +: 20] = rbar_size[i];
				rbar_ctl_img[i][2:0] = rbar_idx[i];
			end
		end
		if (rbar_en) begin
			rbar_ctl_img[0][RBAR_CNT_LSB +: 3] = rbar_cnt;
		end
	end

	// ltr engine state; all but the interval counters read back through the status word
	pcc_ltr_st_e st;
	logic pend_set, pend_clr, sent_en, sent_up, last_req;
	logic [9:0] gap_left;
	logic [7:0] pre_cnt;

	// read channel: one cycle from address to data
	logic [31:0] rd_word;
	logic rd_ok;
	wire [7:0] ra = {s_axi_araddr_i[7:2], 2'b00};
	always_comb begin
		rd_word = 32'h0;
		rd_ok = 1'b1;
		case (ra)
			OFF_CTRL: rd_word = ctrl;
			OFF_RBAR_CFG: rd_word = {20'h0, rbar_cfg};
			OFF_LTR_LAT: rd_word = ltr_img;
			OFF_LTR_GAP: rd_word = {22'h0, gap_us_cfg};
			OFF_LINK_CFG: rd_word = {16'h0, link_cfg};
			OFF_EXT_CFG: rd_word = {16'h0, ext_cfg};
			OFF_PMC: rd_word = pmc_img;
			OFF_PMCSR: rd_word = pmcsr_img;
			OFF_AER: rd_word = aer_img;
			OFF_ARI: rd_word = ari_img;
			OFF_PB: rd_word = pb_img;
			OFF_LTR_IMG: rd_word = ltr_img;
			OFF_EXT_HDR: rd_word = ext_img;
			OFF_LTR_STAT: rd_word = {24'h0, ext_cfg[11:0] == 12'h000, st, last_req, sent_up,
				sent_en, pend_clr, pend_set};
			default: begin
				rd_ok = 1'b0;
				for (int i = 0; i < 3; i++) begin
					if (ra == OFF_RBAR_SIZE0 + 8'(4 * i)) begin
						rd_word = {12'h0, rbar_size[i]};
						rd_ok = 1'b1;
					end
					if (ra == OFF_RBAR_IMG0 + 8'(8 * i)) begin
						rd_word = rbar_cap_img[i];
						rd_ok = 1'b1;
					end
					if (ra == OFF_RBAR_IMG0 + 8'(8 * i + 4)) begin
						rd_word = rbar_ctl_img[i];
						rd_ok = 1'b1;
					end
				end
			end
		endcase
	end

	assign s_axi_arready_o = !s_axi_rvalid_o;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_word;
			s_axi_rresp_o <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// requester ID split and training-set link number
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rid_o <= '0;
			ts_link_number_o <= 8'h00;
			ts_link_valid_o <= 1'b0;
		end else begin
			rid_o.bus <= rid_i[15:8];
			rid_o.dev <= ctrl[CB_ALT_RID] ? 5'h00 : rid_i[7:3];
			rid_o.func <= ctrl[CB_ALT_RID] ? rid_i[7:0] : {5'h00, rid_i[2:0]};
			ts_link_valid_o <= ctrl[CB_DOWNSTREAM];
			ts_link_number_o <= ctrl[CB_DOWNSTREAM] ? link_cfg[7:0] : 8'h00;
		end
	end

	// exported state for user logic that sends its own messages
	assign ltr_enable_o = ltr_enable_i;
	assign func_power_state_o = func_power_state_i;

	// edge detection of enable, link-up and all-functions-off-D0
	logic en_q, up_q, off_q, all_off;
	always_comb begin
		all_off = 1'b1;
		for (int f = 0; f < NUM_FUNC; f++) begin
			if (func_power_state_i[2*f +: 2] == PWR_D0) begin
				all_off = 1'b0;
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_q <= 1'b0;
			up_q <= 1'b0;
			off_q <= 1'b0;
		end else begin
			en_q <= ltr_enable_i;
			up_q <= dl_up_i;
			off_q <= all_off;
		end
	end
	wire en_rise = ltr_enable_i && !en_q;
	wire en_fall = !ltr_enable_i && en_q;
	wire up_rise = dl_up_i && !up_q;
	wire off_rise = all_off && !off_q;
	wire sent = ltr_valid_o && ltr_ready_i;
	wire on_en = ctrl[CB_LTR_ON_EN];
	wire on_pwr = ctrl[CB_LTR_ON_PWR];
	wire clr_fall = on_en && en_fall && sent_en && last_req;
	wire clr_pwr = on_pwr && off_rise && sent_up && last_req;

	// history flags; a send in the same cycle as the event wins
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sent_en <= 1'b0;
			sent_up <= 1'b0;
			last_req <= 1'b0;
		end else begin
			sent_en <= sent || (sent_en && !en_rise);
			sent_up <= sent || (sent_up && !up_rise);
			if (sent) begin
				last_req <= ltr_msg_o.snoop_req || ltr_msg_o.nosnoop_req;
			end
		end
	end

	// pending triggers survive the interval wait
	wire take_set = st == ST_IDLE && pend_set && !pend_clr;
	wire take_clr = st == ST_IDLE && pend_clr;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_set <= 1'b0;
			pend_clr <= 1'b0;
		end else begin
			if (on_en && en_rise) begin
				pend_set <= 1'b1;
			end else if (take_set || en_fall) begin
				pend_set <= 1'b0;
			end
			if (clr_fall || clr_pwr) begin
				pend_clr <= 1'b1;
			end else if (take_clr || en_rise) begin
				pend_clr <= 1'b0;
			end
		end
	end

	// message issue and minimum spacing
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= ST_IDLE;
			ltr_valid_o <= 1'b0;
			ltr_msg_o <= '0;
			gap_left <= 10'h000;
			pre_cnt <= 8'h00;
		end else begin
			case (st)
				ST_IDLE: begin
					if (take_clr) begin
						ltr_msg_o <= '0;
						ltr_valid_o <= 1'b1;
						st <= ST_SEND;
					end else if (take_set) begin
						ltr_msg_o <= '{snoop_req: 1'b1, snoop_lat: snoop_lat,
							nosnoop_req: 1'b1, nosnoop_lat: nosnoop_lat};
						ltr_valid_o <= 1'b1;
						st <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (ltr_ready_i) begin
						ltr_valid_o <= 1'b0;
						gap_left <= gap_us_cfg;
						pre_cnt <= 8'(CYC_PER_US - 1);
						st <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (gap_left == 10'h000) begin
						st <= ST_IDLE;
					end else if (pre_cnt == 8'h00) begin
						gap_left <= gap_left - 10'h001;
						pre_cnt <= 8'(CYC_PER_US - 1);
					end else begin
						pre_cnt <= pre_cnt - 8'h01;
					end
				end
				default: begin
					st <= ST_IDLE;
					ltr_valid_o <= 1'b0;
				end
			endcase
		end
	end

	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	property p_pmc_bits;
		pmc_img[14] == ctrl[CB_PME_D3HOT] && pmc_img[12] == ctrl[CB_PME_D1] && pmc_img[11] ==
			ctrl[CB_PME_D0] && pmc_img[9] == ctrl[CB_D1_SUP];
	endproperty
	a_pmc_bits: assert property (p_pmc_bits) else $error("pme bits wrong");
	property p_nsr;
		pmcsr_img == {28'h0, ctrl[CB_NO_SOFT_RST], 3'h0};
	endproperty
	a_nsr: assert property (p_nsr) else $error("no soft reset bit wrong");
	property p_rbar_absent;
		!rbar_en |-> rbar_cap_img[0] == 32'h0 && rbar_ctl_img[0] == 32'h0;
	endproperty
	a_rbar_absent: assert property (p_rbar_absent) else $error("rbar present");
	property p_rbar_edges;
		rbar_cap_img[0][3:0] == 4'h0 && rbar_cap_img[0][31:24] == 8'h00 &&
			rbar_cap_img[1][3:0] == 4'h0 && rbar_cap_img[1][31:24] == 8'h00;
	endproperty
	a_rbar_edges: assert property (p_rbar_edges) else $error("rbar zero bits");
	property p_idx_order;
		rbar_en && rbar_cnt >= 3'h2 |-> rbar_ctl_img[1][2:0] >= rbar_ctl_img[0][2:0];
	endproperty
	a_idx_order: assert property (p_idx_order) else $error("rbar index order");
	property p_ts_link;
		!ctrl[CB_DOWNSTREAM] |=> ts_link_number_o == 8'h00 && !ts_link_valid_o;
	endproperty
	a_ts_link: assert property (p_ts_link) else $error("link number leaked");
	property p_rid;
		ctrl[CB_ALT_RID] |=> rid_o.dev == 5'h00 && rid_o.func == $past(rid_i[7:0]);
	endproperty
	a_rid: assert property (p_rid) else $error("ari rid split");
	sequence s_en_rise;
		on_en && en_rise && st == ST_IDLE && !pend_clr;
	endsequence
	sequence s_send;
		##1 ltr_valid_o && ltr_msg_o.snoop_lat == $past(snoop_lat);
	endsequence
	property p_en_msg;
		s_en_rise |=> pend_set ##0 s_send;
	endproperty
	a_en_msg: assert property (p_en_msg) else $error("enable message missing");
	property p_gap;
		sent && gap_us_cfg != 10'h000 |=> !ltr_valid_o [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("interval broken");
	property p_no_auto;
		!on_en && !on_pwr && !pend_set && !pend_clr |=> !pend_set && !pend_clr;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("unrequested message");
	property p_hold;
		ltr_valid_o && !ltr_ready_i |=> ltr_valid_o && $stable(ltr_msg_o);
	endproperty
	a_hold: assert property (p_hold) else $error("message dropped");
endmodule // pcc_top
`default_nettype wire

// file: tb/pcc_ltr_sink.sv
`timescale 1ns/1ps
`default_nettype none
// upstream port stand-in: takes latency messages promptly or after a stall
module pcc_ltr_sink (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	input wire logic ltr_valid_i,
	output logic ltr_ready_o,
	input wire pcc_pkg::pcc_ltr_msg_s ltr_msg_i,
	output int n_msg_o,
	output int gap_o,
	output pcc_pkg::pcc_ltr_msg_s last_o,
	output logic held_bad_o
);
	import pcc_pkg::*;
	int wait_c;
	int since_c;
	pcc_ltr_msg_s held;
	// a slow sink holds ready low for three cycles of valid
	always_comb ltr_ready_o = ltr_valid_i && (!slow_i || wait_c >= 3);
	// count accepted messages and the cycles between acceptances
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_c <= 0;
			since_c <= 0;
			n_msg_o <= 0;
			gap_o <= 0;
			last_o <= '0;
			held <= '0;
			held_bad_o <= 1'b0;
		end else begin
			since_c <= since_c + 1;
			wait_c <= (ltr_valid_i && !ltr_ready_o) ? wait_c + 1 : 0;
			held <= ltr_msg_i;
			// a stalled message must stand unchanged
			if (wait_c > 0 && ltr_msg_i !== held) begin
				held_bad_o <= 1'b1;
			end
			if (ltr_valid_i && ltr_ready_o) begin
				n_msg_o <= n_msg_o + 1;
				gap_o <= since_c;
				since_c <= 1;
				last_o <= ltr_msg_i;
			end
		end
	end
endmodule // pcc_ltr_sink
`default_nettype wire

// file: tb/pcc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module pcc_top_test;
	import pcc_pkg::*;
	typedef struct packed {
		logic [15:0] ctrl, power_mgmt_capabilities_reg, pmcsr, aer, pb;
	} pcc_row_s;
	localparam pcc_row_s ROWS [10] = '{'{16'h0, 16'h0, 16'h0, 16'h0, 16'h0},
		'{16'h1, 16'h4000, 16'h0, 16'h0, 16'h0}, '{16'h2, 16'h1000, 16'h0, 16'h0, 16'h0},
		'{16'h4, 16'h0800, 16'h0, 16'h0, 16'h0}, '{16'h8, 16'h0200, 16'h0, 16'h0, 16'h0},
		'{16'h10, 16'h0, 16'h8, 16'h0, 16'h0}, '{16'h40, 16'h0, 16'h0, 16'h80, 16'h0},
		'{16'h80, 16'h0, 16'h0, 16'h20, 16'h0}, '{16'h200, 16'h0, 16'h0, 16'h0, 16'h1},
		'{16'h2df, 16'h5a00, 16'h8, 16'ha0, 16'h1}};
	localparam pcc_ltr_msg_s SET_MSG = '{1'b1, 10'h2aa, 1'b1, 10'h155};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic len = 1'b0;
	logic dlup = 1'b0;
	logic [3:0] pwr = 4'h0;
	logic [15:0] rid_in = 16'h0;
	logic slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tsv, len_o, lv, lr, bad;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rdv;
	logic [7:0] tsn;
	logic [3:0] pwr_o;
	pcc_rid_s rid;
	pcc_ltr_msg_s lm, last;
	int n_msg, gap;
	int n_mismatch = 0;
	int total_checks = 0;
	// free-running clock, 8 ns period
	always #4 mclk = ~mclk;
	pcc_top pcc_top_i (.mclk_i(mclk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .ltr_enable_i(len), .dl_up_i(dlup),
		.func_power_state_i(pwr), .rid_i(rid_in), .rid_o(rid), .ts_link_number_o(tsn),
		.ts_link_valid_o(tsv), .ltr_enable_o(len_o), .func_power_state_o(pwr_o),
		.ltr_valid_o(lv), .ltr_ready_i(lr), .ltr_msg_o(lm));
	pcc_ltr_sink pcc_ltr_sink_i (.mclk_i(mclk), .rst_n_i(rst_n), .slow_i(slow),
		.ltr_valid_i(lv), .ltr_ready_o(lr), .ltr_msg_i(lm), .n_msg_o(n_msg), .gap_o(gap),
		.last_o(last), .held_bad_o(bad));
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic give_up();
		n_mismatch++;
		final_report();
	endtask
	// bus write: handshakes sampled at the rising edge, each channel released at its own edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge mclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rsp = bresp;
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				return;
			end
		end
		give_up();
	endtask
	// bus read
	task automatic rd(input logic [7:0] a);
		logic ta, tb;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge mclk);
			ta = arvalid && arready;
			tb = rvalid;
			rdv = rdata;
			rsp = rresp;
			if (ta) arvalid <= 1'b0;
			if (tb) begin
				rready <= 1'b0;
				return;
			end
		end
		give_up();
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		`CHK(rdv & m, e)
	endtask
	task automatic wait_msg(input int k);
		for (int n = 0; n < 2000; n++) begin
			@(posedge mclk);
			if (n_msg >= k) return;
		end
		give_up();
	endtask
	task automatic quiet(input int k);
		repeat (400) @(posedge mclk);
		`CHK(n_msg, k)
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		dlup <= 1'b1;
		rdm(OFF_CTRL, 32'hffff_ffff, RST_CTRL);
		`CHK(lv, 1'b0)
		foreach (ROWS[i]) begin
			wr(OFF_CTRL, {16'h0, ROWS[i].ctrl});
			rdm(OFF_PMC, 32'h5a00, {16'h0, ROWS[i].power_mgmt_capabilities_reg});
			rdm(OFF_PMCSR, 32'h8, {16'h0, ROWS[i].pmcsr});
			rdm(OFF_AER, 32'ha0, {16'h0, ROWS[i].aer});
			rdm(OFF_PB, 32'h1, {16'h0, ROWS[i].pb});
		end
		$display("table test done");
		wr(8'hfc, 32'h1);
		`CHK(rsp, RESP_SLVERR)
		wr(OFF_PMC, 32'h1);
		`CHK(rsp, RESP_SLVERR)
		rdm(8'hfc, 32'hffff_ffff, 32'h0);
		`CHK(rsp, RESP_SLVERR)
		wr(OFF_CTRL, 32'h20);
		wr(OFF_RBAR_CFG, 32'ha5a);
		wr(OFF_RBAR_SIZE0, 32'hffff_ffff);
		rdm(OFF_RBAR_IMG0, 32'hffff_ffff, 32'h00ff_fff0);
		rdm(8'h4c, 32'he0, 32'h40);
		rdm(8'h4c, 32'h7, 32'h3);
		rdm(8'h54, 32'h7, 32'h3);
		rdm(8'h5c, 32'h7, 32'h0);
		wr(OFF_CTRL, 32'h0);
		rdm(OFF_RBAR_IMG0, 32'hffff_ffff, 32'h0);
		$display("resizable bar test done");
		wr(OFF_LINK_CFG, 32'h3c5a);
		wr(OFF_CTRL, 32'h1000);
		repeat (2) @(posedge mclk);
		`CHK({tsv, tsn}, 9'h15a)
		rdm(OFF_ARI, 32'hff00, 32'h3c00);
		rid_in <= 16'habcd;
		wr(OFF_CTRL, 32'h0);
		repeat (2) @(posedge mclk);
		`CHK({tsv, tsn}, 9'h000)
		`CHK(rid, {8'hab, 5'h19, 8'h05})
		wr(OFF_CTRL, 32'h100);
		repeat (2) @(posedge mclk);
		`CHK(rid, {8'hab, 5'h00, 8'hcd})
		wr(OFF_EXT_CFG, 32'h4123);
		rdm(OFF_EXT_HDR, 32'hffff_0000, 32'h1234_0000);
		wr(OFF_EXT_CFG, 32'h4000);
		rdm(OFF_LTR_STAT, 32'h80, 32'h80);
		wstrb <= 4'h4;
		wr(OFF_LTR_LAT, 32'h03ff_03ff);
		wstrb <= 4'hf;
		rdm(OFF_LTR_IMG, 32'h03ff_03ff, 32'h00ff_0000);
		wr(OFF_LTR_LAT, 32'h0155_02aa);
		rdm(OFF_LTR_IMG, 32'h03ff_03ff, 32'h0155_02aa);
		$display("field test done");
		wr(OFF_LTR_GAP, 32'h2);
		wr(OFF_CTRL, 32'h400);
		len <= 1'b1;
		wait_msg(1);
		`CHK(last, SET_MSG)
		@(posedge mclk);
		len <= 1'b0;
		wait_msg(2);
		`CHK(last, 22'h0)
		`CHK(gap >= 250, 1'b1)
		slow <= 1'b1;
		len <= 1'b1;
		wait_msg(3);
		`CHK({bad, last}, {1'b0, SET_MSG})
		slow <= 1'b0;
		wr(OFF_CTRL, 32'h0);
		len <= 1'b0;
		quiet(3);
		`CHK(len_o, 1'b0)
		len <= 1'b1;
		quiet(3);
		wr(OFF_CTRL, 32'h400);
		len <= 1'b0;
		quiet(3);
		$display("enable message test done");
		wr(OFF_CTRL, 32'hc00);
		dlup <= 1'b0;
		@(posedge mclk);
		dlup <= 1'b1;
		len <= 1'b1;
		wait_msg(4);
		pwr <= 4'h3;
		quiet(4);
		pwr <= 4'hf;
		wait_msg(5);
		`CHK(last, 22'h0)
		`CHK(pwr_o, 4'hf)
		pwr <= 4'h0;
		len <= 1'b0;
		quiet(5);
		len <= 1'b1;
		wait_msg(6);
		wr(OFF_CTRL, 32'h400);
		pwr <= 4'hf;
		quiet(6);
		$display("power message test done");
		wr(OFF_CTRL, 32'h1fff);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdm(OFF_CTRL, 32'hffff_ffff, RST_CTRL);
		`CHK({lv, tsv}, 2'b00)
		$display("reset test done");
		final_report();
	end
endmodule // pcc_top_test
`default_nettype wire
